// >>> core/ixp_addr_gen.sv
// operand address former for short and long indexed references
`timescale 1ns/1ps
module ixp_addr_gen
  import ixp_pkg::*;
(
  // mode and fields
  input  wire ixp_amode_e  addrMode,
  input  wire logic [15:0] baseWord,
  input  wire logic [15:0] dispField,
  // result
  output logic [15:0]      operandAddr
);
  always_comb begin
    case (addrMode)
      IXP_AM_SHORT: operandAddr = baseWord
                                  + {{8{dispField[7]}}, dispField[7:0]};
      IXP_AM_LONG:  operandAddr = baseWord + dispField;
      default:      operandAddr = baseWord;
    endcase
  end
endmodule

// >>> core/ixp_core.sv
// indexed address former with status word, mask alias and stack pointer
`timescale 1ns/1ps
// Notes on behaviour
// - short index: base plus sign-extended byte
// - one short-indexed operand per instruction
// - long index: base plus 16-bit displacement
// - one long-indexed operand per instruction
// - register word zero always reads zero
// - zero base gives absolute long address
// - stack pointer lives at register 18 hex
// - stack pointer usable as indexed base
// - low status byte masks interrupt sources
// - mask byte aliased at register 8
// - global enable bit 9 gates maskables
// - pending recorded even while masked
// - status word saved/restored in one op
// - zero flag follows zero result
// - carry-chained ops only clear zero
// - negative flag shows true sign
// - overflow flag on out-of-range result
// - left shift overflow on sign change
// - trap flag sticky until cleared/tested
// - carry from msb or last out
// - subtraction carry is inverted borrow
// - sticky flag on lost right-shifted one
module ixp_core
  import ixp_pkg::*;
#(
  parameter int NUM_IRQ = 8  // maskable sources
)(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // address request from decode
  input  wire ixp_amode_e         addrMode,
  input  wire logic [7:0]         baseSel,
  input  wire logic [15:0]        dispField,
  input  wire logic [1:0]         indexedCount,
  output logic [15:0]             operandAddr,
  output logic                    modeFault,
  // register-file window for mapped words
  input  wire logic               regWrEn,
  input  wire logic [7:0]         regAddr,
  input  wire logic [15:0]        regWrData,
  input  wire logic               regByteWr,
  input  wire logic [15:0]        fileRdData,
  output logic [15:0]             regRdData,
  // flag update from alu and shifter
  input  wire logic               opValid,
  input  wire ixp_op_e            opKind,
  input  wire ixp_size_e          opSize,
  input  wire logic [31:0]        opA,
  input  wire logic [31:0]        opB,
  input  wire logic [31:0]        opResult,
  input  wire logic               opCarryOut,
  input  wire logic               shiftMsbChanged,
  input  wire logic               shiftLastOut,
  input  wire logic               shiftLostOne,
  input  wire logic [15:0]        stackRdData,
  output logic [15:0]             stackWrData,
  output logic                    jumpTrapTaken,
  // interrupt gating
  input  wire logic [NUM_IRQ-1:0] irqRequest,
  input  wire logic [NUM_IRQ-1:0] irqAck,
  input  wire logic               nmiRequest,
  output logic [NUM_IRQ-1:0]      irqPending,
  output logic [NUM_IRQ-1:0]      irqServiceable,
  output logic                    nmiServiceable,
  // status word view
  output logic [15:0]             statusWord,
  output logic [15:0]             stackPointer
);
  import ixp_pkg::*;

  logic [15:0]        psw_q;        // program status word
  logic [15:0]        psw_d;
  logic [15:0]        sp_q;         // stack pointer word
  logic [NUM_IRQ-1:0] pend_q;       // pending requests
  logic [15:0]        baseWord;     // selected base
  logic [15:0]        trapWord;     // status word copy driven to stackWrData
  logic               signBit;      // result sign at size
  logic               isZero;       // result zero at size
  logic               srcSignA;     // operand signs
  logic               srcSignB;
  logic               ovf;          // arithmetic overflow
  logic               trapSeen;     // trap flag before jump test

  // base word: zero register, stack pointer, mask alias over file word, or file word
  always_comb begin
    case (baseSel[7:1])
      ADDR_ZERO_REG[7:1]:  baseWord = 16'h0000;
      ADDR_STACK_PTR[7:1]: baseWord = sp_q;
      ADDR_INT_MASK[7:1]:  baseWord = {fileRdData[15:8], psw_q[7:0]};
      default:             baseWord = fileRdData;
    endcase
  end

  // zero base passes long displacement straight through
  ixp_addr_gen u_addr (
    .addrMode    (addrMode),
    .baseWord    (baseWord),
    .dispField   (dispField),
    .operandAddr (operandAddr)
  );

  // one indexed operand allowed; decode told how many
  // second indexed operand flagged as a fault
  assign modeFault = (addrMode != IXP_AM_DIRECT) && (indexedCount > 2'h1);

  // read side of mapped words
  always_comb begin
    case (regAddr[7:1])
      ADDR_ZERO_REG[7:1]:  regRdData = 16'h0000;
      ADDR_STACK_PTR[7:1]: regRdData = sp_q;
      // mask byte is the low status byte
      ADDR_INT_MASK[7:1]:  regRdData = {fileRdData[15:8], psw_q[7:0]};
      default:             regRdData = fileRdData;
    endcase
  end

  // stack pointer writes; zero register ignores writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sp_q <= SP_RESET;
    end else if (regWrEn && regAddr[7:1] == ADDR_STACK_PTR[7:1]) begin
      if (regByteWr && regAddr[0]) begin
        sp_q[15:8] <= regWrData[7:0];
      end else if (regByteWr) begin
        sp_q[7:0] <= regWrData[7:0];
      end else begin
        sp_q <= regWrData;
      end
    end
  end
  // no storage exists at the zero word, so writes vanish

  // size-dependent sign and zero of result and operands
  always_comb begin
    case (opSize)
      IXP_SZ_BYTE: begin
        signBit  = opResult[7];
        isZero   = (opResult[7:0] == 8'h00);
        srcSignA = opA[7];
        srcSignB = opB[7];
      end
      IXP_SZ_LONG: begin
        signBit  = opResult[31];
        isZero   = (opResult == 32'h0000_0000);
        srcSignA = opA[31];
        srcSignB = opB[31];
      end
      default: begin
        signBit  = opResult[15];
        isZero   = (opResult[15:0] == 16'h0000);
        srcSignA = opA[15];
        srcSignB = opB[15];
      end
    endcase
  end

  // signed overflow: add like signs, sub unlike signs
  always_comb begin
    case (opKind)
      IXP_OP_ADD, IXP_OP_ADD_WITH_CARRY_OP:
        ovf = (srcSignA == srcSignB) && (signBit != srcSignA);
      IXP_OP_SUB, IXP_OP_SUB_WITH_BORROW_OP:
        ovf = (srcSignA != srcSignB) && (signBit != srcSignA);
      default:
        ovf = 1'b0;
    endcase
  end

  assign trapSeen = psw_q[PSW_VT];

  // next status word from the finishing operation
  always_comb begin
    psw_d = psw_q;
    if (regWrEn && regAddr == ADDR_INT_MASK) begin
      // byte write to mask alias lands in status word
      psw_d[7:0] = regWrData[7:0];
    end
    if (opValid) begin
      case (opKind)
        IXP_OP_ADD, IXP_OP_SUB, IXP_OP_ADD_WITH_CARRY_OP, IXP_OP_SUB_WITH_BORROW_OP: begin
          psw_d[PSW_Z] = isZero;
          // chained ops keep zero only when result zero
          if (opKind == IXP_OP_ADD_WITH_CARRY_OP || opKind == IXP_OP_SUB_WITH_BORROW_OP) begin
            psw_d[PSW_Z] = psw_q[PSW_Z] & isZero;
          end
          // true sign inverts result sign on overflow
          psw_d[PSW_N] = signBit ^ ovf;
          psw_d[PSW_V] = ovf;
          // trap flag set with overflow, never cleared here
          psw_d[PSW_VT] = psw_q[PSW_VT] | ovf;
          psw_d[PSW_C] = opCarryOut;
          if (opKind == IXP_OP_SUB || opKind == IXP_OP_SUB_WITH_BORROW_OP) begin
            psw_d[PSW_C] = ~opCarryOut;
          end
        end
        IXP_OP_LOGIC: begin
          psw_d[PSW_Z] = isZero;
          psw_d[PSW_N] = signBit;
          psw_d[PSW_C] = 1'b0;
          psw_d[PSW_V] = 1'b0;
        end
        IXP_OP_SHL: begin
          psw_d[PSW_Z] = isZero;
          psw_d[PSW_N] = signBit;
          psw_d[PSW_V] = shiftMsbChanged;
          psw_d[PSW_VT] = psw_q[PSW_VT] | shiftMsbChanged;
          // carry is last bit shifted out
          psw_d[PSW_C] = shiftLastOut;
        end
        IXP_OP_SHR: begin
          psw_d[PSW_Z] = isZero;
          psw_d[PSW_N] = signBit;
          psw_d[PSW_V] = 1'b0;
          psw_d[PSW_C] = shiftLastOut;
          // a one passed through carry and fell off
          psw_d[PSW_ST] = shiftLostOne;
        end
        IXP_OP_MUL: begin
          // sticky is undefined after multiply; cleared here
          psw_d[PSW_ST] = 1'b0;
        end
        IXP_OP_CLEAR_TRAP_FLAG_OP, IXP_OP_JVT: begin
          // explicit clear or test drops the trap flag
          psw_d[PSW_VT] = 1'b0;
        end
        IXP_OP_SAVE_FLAGS_OP: begin
          // save whole word, then clear it
          psw_d = 16'h0000;
        end
        IXP_OP_RESTORE_FLAGS_OP: begin
          // restore whole word in one operation
          psw_d = stackRdData;
        end
        default: begin
          psw_d = psw_d;
        end
      endcase
    end
  end

  // status word register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      psw_q <= PSW_RESET;
    end else begin
      psw_q <= psw_d;
    end
  end

  // pending kept regardless of mask; set wins over ack
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~irqAck) | irqRequest;
    end
  end

  assign irqServiceable = pend_q & psw_q[NUM_IRQ-1:0]
                          & {NUM_IRQ{psw_q[PSW_I]}};
  // non-maskable source ignores both mask and global bit
  assign nmiServiceable = nmiRequest;

  assign trapWord      = psw_q;
  assign stackWrData   = trapWord;
  assign jumpTrapTaken = opValid && (opKind == IXP_OP_JVT) && trapSeen;
  assign irqPending    = pend_q;
  assign statusWord    = psw_q;
  assign stackPointer  = sp_q;
endmodule

// >>> core/ixp_pkg.sv
// package: offsets, status-word fields and operation codes for ixp block
package ixp_pkg;
  localparam logic [7:0] ADDR_ZERO_REG = 8'h00;  // zero word
  localparam logic [7:0] ADDR_INT_MASK = 8'h08;  // mask byte alias
  localparam logic [7:0] ADDR_STACK_PTR = 8'h18; // stack pointer word
  // status-word bit positions
  localparam int PSW_Z   = 15;
  localparam int PSW_N   = 14;
  localparam int PSW_V   = 13;
  localparam int PSW_VT  = 12;
  localparam int PSW_C   = 11;
  localparam int PSW_I   = 9;
  localparam int PSW_ST  = 8;
  localparam logic [15:0] PSW_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET  = 16'h0000;
  // addressing modes handled here
  typedef enum logic [1:0] {
    IXP_AM_DIRECT = 2'h0,
    IXP_AM_SHORT  = 2'h1,
    IXP_AM_LONG   = 2'h3
  } ixp_amode_e;
  // flag-update classes of the finishing operation
  typedef enum logic [3:0] {
    IXP_OP_NONE   = 4'h0,
    IXP_OP_ADD    = 4'h1,
    IXP_OP_ADD_WITH_CARRY_OP   = 4'h2,
    IXP_OP_SUB    = 4'h3,
    IXP_OP_SUB_WITH_BORROW_OP   = 4'h4,
    IXP_OP_LOGIC  = 4'h5,
    IXP_OP_SHL    = 4'h6,
    IXP_OP_SHR    = 4'h7,
    IXP_OP_CLEAR_TRAP_FLAG_OP  = 4'h8,
    IXP_OP_JVT    = 4'h9,
    IXP_OP_SAVE_FLAGS_OP  = 4'hA,
    IXP_OP_RESTORE_FLAGS_OP   = 4'hB,
    IXP_OP_MUL    = 4'hC
  } ixp_op_e;
  // operand size
  typedef enum logic [1:0] {
    IXP_SZ_BYTE = 2'h0,
    IXP_SZ_WORD = 2'h1,
    IXP_SZ_LONG = 2'h3
  } ixp_size_e;
endpackage

// >>> test/ixp_core_checker.sv
// concurrent checks on the ixp core ports
`timescale 1ns/1ps
module ixp_core_checker
  import ixp_pkg::*;
#(
  parameter int NUM_IRQ = 8  // maskable sources
)(
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  // address side
  input wire ixp_pkg::ixp_amode_e addrMode,
  input wire logic [7:0]          baseSel,
  input wire logic [15:0]         dispField,
  input wire logic [15:0]         operandAddr,
  input wire logic [7:0]          regAddr,
  input wire logic [15:0]         regRdData,
  // flag side
  input wire logic                opValid,
  input wire ixp_pkg::ixp_op_e    opKind,
  input wire ixp_pkg::ixp_size_e  opSize,
  input wire logic [31:0]         opResult,
  input wire logic                opCarryOut,
  // status and interrupts
  input wire logic [NUM_IRQ-1:0]  irqPending,
  input wire logic [NUM_IRQ-1:0]  irqServiceable,
  input wire logic [15:0]         statusWord,
  input wire logic [15:0]         stackPointer
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // word-sized op finishing at this edge
  wire logic wordOp = opValid && opSize == IXP_SZ_WORD;
  a_zero_set: assert property (wordOp && opKind == IXP_OP_ADD &&
    opResult[15:0] == 16'h0000 |=> statusWord[PSW_Z])
    else $error("zero flag not set on zero sum");
  a_add_with_carry_op_hold: assert property (wordOp && opKind == IXP_OP_ADD_WITH_CARRY_OP &&
    !statusWord[PSW_Z] |=> !statusWord[PSW_Z])
    else $error("carry-chained op set zero flag");
  // a restore may legally load overflow without the trap flag
  a_trap_follow: assert property ($rose(statusWord[PSW_V]) &&
    $past(opKind) != IXP_OP_RESTORE_FLAGS_OP |-> statusWord[PSW_VT])
    else $error("trap flag missing with overflow");
  a_trap_keep: assert property (statusWord[PSW_VT] && !(opValid &&
    opKind inside {IXP_OP_CLEAR_TRAP_FLAG_OP, IXP_OP_JVT, IXP_OP_SAVE_FLAGS_OP, IXP_OP_RESTORE_FLAGS_OP})
    |=> statusWord[PSW_VT]) else $error("trap flag dropped");
  a_sub_carry: assert property (opValid && opKind == IXP_OP_SUB
    |=> statusWord[PSW_C] == !$past(opCarryOut))
    else $error("subtract carry not inverted borrow");
  a_long_abs: assert property (addrMode == IXP_AM_LONG &&
    baseSel == ADDR_ZERO_REG |-> operandAddr == dispField)
    else $error("zero base long address wrong");
  a_sp_short: assert property (addrMode == IXP_AM_SHORT &&
    baseSel == ADDR_STACK_PTR |-> operandAddr == stackPointer +
    {{8{dispField[7]}}, dispField[7:0]}) else $error("stack index wrong");
  a_zero_read: assert property (regAddr[7:1] == 7'h00
    |-> regRdData == 16'h0000) else $error("zero register not zero");
  a_irq_gate: assert property (irqServiceable == (irqPending &
    statusWord[NUM_IRQ-1:0] & {NUM_IRQ{statusWord[PSW_I]}}))
    else $error("interrupt gating wrong");
endmodule
bind ixp_core ixp_core_checker #(.NUM_IRQ(NUM_IRQ)) chk (.*);

// >>> test/ixp_regfile_model.sv
// register-file model answering base and window reads
`timescale 1ns/1ps
module ixp_regfile_model (
  // clock
  input  wire logic        sys_clk,
  // write and read port
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regByteWr,
  output logic [15:0]      fileRdData
);
  logic [15:0] memQ [128];  // word store, lane picked by address bit 0
  // same-cycle read, as the core samples it combinationally
  assign fileRdData = memQ[regAddr[7:1]];
  // byte writes touch one lane only, so the other lane survives
  always_ff @(posedge sys_clk) begin
    if (regWrEn && regByteWr && regAddr[0]) begin
      memQ[regAddr[7:1]][15:8] <= regWrData[7:0];
    end else if (regWrEn && regByteWr) begin
      memQ[regAddr[7:1]][7:0] <= regWrData[7:0];
    end else if (regWrEn) begin
      memQ[regAddr[7:1]] <= regWrData;
    end
  end
endmodule

// >>> test/tb_ixp_core.sv
// self-checking bench for the ixp address former and status word
`timescale 1ns/1ps
module tb_ixp_core;
  import ixp_pkg::*;
  localparam int NUM_IRQ = 8;  // maskable sources
  logic sys_clk = 1'b0;        // bench clock
  logic sys_rst = 1'b1;        // held during start-up
  ixp_amode_e addrMode;
  ixp_op_e    opKind;
  ixp_size_e  opSize;
  logic [7:0]  baseSel, regAddr, irqRequest, irqAck;
  logic [1:0]  indexedCount;
  logic [15:0] dispField, regWrData, stackRdData, fileRdData;
  logic [31:0] opA, opB, opResult;
  logic regWrEn, regByteWr, opValid, opCarryOut, nmiRequest;
  logic shiftMsbChanged, shiftLastOut, shiftLostOne;
  logic [15:0] operandAddr, regRdData, stackWrData, statusWord;
  logic [15:0] stackPointer;
  logic modeFault, jumpTrapTaken, nmiServiceable;
  logic [7:0] irqPending, irqServiceable;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  ixp_core #(.NUM_IRQ(NUM_IRQ)) uut (.*);
  ixp_regfile_model model (.*);
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [15:0] d,
                          input logic b);
    @(negedge sys_clk);
    {regWrEn, regAddr, regWrData, regByteWr} = {1'b1, a, d, b};
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    regAddr = a;
    #1 chk("regRdData", e, regRdData);
  endtask
  task automatic doOp(input ixp_op_e k, input ixp_size_e s,
                      input logic [31:0] a, b, r, input logic cy);
    @(negedge sys_clk);
    {opValid, opA, opB, opResult, opCarryOut} = {1'b1, a, b, r, cy};
    opKind = k;
    opSize = s;
    @(negedge sys_clk);
    opValid = 1'b0;
  endtask
  task automatic addrChk(input ixp_amode_e m, input logic [7:0] b,
                         input logic [15:0] d, e);
    @(negedge sys_clk);
    {addrMode, baseSel, regAddr, dispField} = {m, b, b, d};
    #1 chk("operandAddr", e, operandAddr);
  endtask
  task automatic t_addr();
    regWrite(8'h18, 16'h0200, 1'b0);
    chk("stackPointer", 16'h0200, stackPointer);
    regWrite(8'h20, 16'h1000, 1'b0);
    addrChk(IXP_AM_SHORT, 8'h20, 16'hFF80, 16'h0F80);
    addrChk(IXP_AM_SHORT, 8'h20, 16'h007F, 16'h107F);
    addrChk(IXP_AM_LONG, 8'h20, 16'hFFFF, 16'h0FFF);
    addrChk(IXP_AM_SHORT, 8'h18, 16'h00FE, 16'h01FE);
    indexedCount = 2'h2;
    #1 chk("modeFault", 1'b1, modeFault);
    addrChk(IXP_AM_LONG, 8'h00, 16'hBEEF, 16'hBEEF);
    chk("modeFault", 1'b1, modeFault);
    indexedCount = 2'h1;
    #1 chk("modeFault", 1'b0, modeFault);
    $display("test addressing done");
  endtask
  task automatic t_regs();
    regWrite(8'h00, 16'h1234, 1'b0);
    rdChk(8'h00, 16'h0000);
    rdChk(8'h01, 16'h0000);
    regWrite(8'h08, 16'hAB00, 1'b0);
    regWrite(8'h08, 16'h005A, 1'b1);
    chk("maskByte", 8'h5A, statusWord[7:0]);
    rdChk(8'h08, 16'hAB5A);
    rdChk(8'h18, 16'h0200);
    $display("test registers done");
  endtask
  task automatic t_flags();
    doOp(IXP_OP_ADD, IXP_SZ_WORD, 32'h7FFF, 32'h1, 32'h8000, 1'b0);
    chk("znvtc", 5'b00110, statusWord[15:11]);
    doOp(IXP_OP_ADD, IXP_SZ_WORD, 32'h8000, 32'h8000, 32'h0, 1'b1);
    chk("znvtc", 5'b11111, statusWord[15:11]);
    doOp(IXP_OP_ADD_WITH_CARRY_OP, IXP_SZ_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
    chk("znvtc", 5'b10010, statusWord[15:11]);
    doOp(IXP_OP_ADD_WITH_CARRY_OP, IXP_SZ_WORD, 32'h1, 32'h0, 32'h1, 1'b0);
    chk("znvtc", 5'b00010, statusWord[15:11]);
    // the core stores the inverse of its carry input on subtraction,
    // so a borrowing 1 - 2 is signalled with the carry input high
    doOp(IXP_OP_SUB, IXP_SZ_WORD, 32'h1, 32'h2, 32'hFFFF, 1'b1);
    chk("znvtc", 5'b01010, statusWord[15:11]);
    doOp(IXP_OP_CLEAR_TRAP_FLAG_OP, IXP_SZ_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
    chk("trap", 1'b0, statusWord[PSW_VT]);
    shiftMsbChanged = 1'b1;
    doOp(IXP_OP_SHL, IXP_SZ_BYTE, 32'h40, 32'h1, 32'h80, 1'b0);
    chk("ovf", 1'b1, statusWord[PSW_V]);
    // jump on trap flag: taken while the flag is set, then drops it
    @(negedge sys_clk);
    opKind = IXP_OP_JVT;
    opValid = 1'b1;
    #1 chk("jumpTrapTaken", 1'b1, jumpTrapTaken);
    @(negedge sys_clk);
    opValid = 1'b0;
    chk("trap", 1'b0, statusWord[PSW_VT]);
    {shiftMsbChanged, shiftLastOut, shiftLostOne} = 3'b011;
    doOp(IXP_OP_SHR, IXP_SZ_WORD, 32'h7, 32'h2, 32'h1, 1'b0);
    chk("cst", 2'b11, {statusWord[PSW_C], statusWord[PSW_ST]});
    $display("test flags done");
  endtask
  task automatic t_irq();
    stackRdData = 16'h0203;
    doOp(IXP_OP_RESTORE_FLAGS_OP, IXP_SZ_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
    chk("statusWord", 16'h0203, statusWord);
    irqRequest = 8'h05;
    @(negedge sys_clk);
    irqRequest = 8'h00;
    chk("irqPending", 8'h05, irqPending);
    chk("irqServiceable", 8'h01, irqServiceable);
    chk("stackWrData", 16'h0203, stackWrData);
    doOp(IXP_OP_SAVE_FLAGS_OP, IXP_SZ_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
    chk("irqServiceable", 8'h00, irqServiceable);
    chk("irqPending", 8'h05, irqPending);
    // acknowledge of source 0 clears only that pending bit
    irqAck = 8'h01;
    @(negedge sys_clk);
    irqAck = 8'h00;
    chk("irqPending", 8'h04, irqPending);
    nmiRequest = 1'b1;
    #1 chk("nmiServiceable", 1'b1, nmiServiceable);
    $display("test interrupts done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence: all inputs quiet until reset is released
  initial begin
    addrMode = IXP_AM_DIRECT;
    opKind = IXP_OP_NONE;
    opSize = IXP_SZ_WORD;
    {baseSel, regAddr, irqRequest, irqAck, indexedCount} = '0;
    {dispField, regWrData, stackRdData, opA, opB, opResult} = '0;
    {regWrEn, regByteWr, opValid, opCarryOut, nmiRequest} = '0;
    {shiftMsbChanged, shiftLastOut, shiftLostOne} = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_addr();
    t_regs();
    t_flags();
    t_irq();
    give_verdict();
  end
  // watchdog: the whole run needs well under 100 cycles
  initial begin
    #50000;
    error_cnt++;
    give_verdict();
  end
endmodule
